// ===== design/phybm_pkg.sv
package phybm_pkg;

    // register indexes
    localparam logic [4:0] IDX_BASIC_CTRL = 5'h00;
    localparam logic [4:0] IDX_BASIC_STAT = 5'h01;
    localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
    localparam logic [4:0] IDX_IDENT_LOW = 5'h03;
    localparam logic [4:0] IDX_AN_ADV = 5'h04;
    localparam logic [4:0] IDX_AN_PARTNER = 5'h05;
    localparam logic [4:0] IDX_AN_EXPAN = 5'h06;
    localparam logic [4:0] IDX_MODE_CTRL = 5'h11;
    localparam logic [4:0] IDX_SPEC_MODES = 5'h12;
    localparam logic [4:0] IDX_SPEC_IND = 5'h1b;
    localparam logic [4:0] IDX_IRQ_SRC = 5'h1d;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h1e;
    localparam logic [4:0] IDX_SPEC_CTRL = 5'h1f;

    // vendor storage slots
    localparam int VEND_SLOTS = 6;
    localparam logic [2:0] SLOT_MODE_CTRL = 3'h0;
    localparam logic [2:0] SLOT_SPEC_MODES = 3'h1;
    localparam logic [2:0] SLOT_SPEC_IND = 3'h2;
    localparam logic [2:0] SLOT_IRQ_SRC = 3'h3;
    localparam logic [2:0] SLOT_IRQ_MASK = 3'h4;
    localparam logic [2:0] SLOT_SPEC_CTRL = 3'h5;

    // basic control field positions
    localparam int CTRL_SOFT_RST = 15;
    localparam int CTRL_LOOPBACK = 14;
    localparam int CTRL_SPEED = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_PWR_DOWN = 11;
    localparam int CTRL_AN_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_COL_TEST = 7;
    localparam logic [15:0] CTRL_WR_MASK = 16'hfb80;
    localparam logic [15:0] CTRL_RST_VAL = 16'h0000;

    // basic status field positions
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_RFAULT = 4;
    localparam int STAT_LINK = 2;
    localparam int STAT_JABBER = 1;
    // T4=0, 100FD/100HD/10FD/10HD=1, AN ability=1, extended=1
    localparam logic [15:0] STAT_FIXED = 16'h7809;

    localparam logic [15:0] AN_ADV_RST_VAL = 16'h0001;
    localparam logic [15:0] VEND_RST_VAL = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // soft reset duration
    localparam int CLK_MHZ = 200;
    localparam int SOFT_RST_NS = 1000;
    localparam int SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 12;

endpackage

// ===== design/phybm_regs.sv
`timescale 1ns/1ps
module phybm_regs #(
    parameter logic [15:0] IDENT_HIGH = 16'h1234, // arbitrary value
    parameter logic [15:0] IDENT_LOW = 16'h5678 // arbitrary value
) (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic [4:0] acc_index, // register index
    input wire logic acc_wr, // write strobe, one cycle
    input wire logic acc_rd, // read strobe, one cycle
    input wire logic [15:0] acc_wdata, // write data
    output logic [15:0] acc_rdata, // read data
    output logic acc_rvalid, // read data valid pulse
    input wire logic speed_sel_pin, // speed strap pin
    input wire logic link_up_in, // live link condition
    input wire logic remote_fault_in, // live remote fault
    input wire logic jabber_in, // live jabber condition
    input wire logic an_done_in, // negotiation finished pulse
    input wire logic an_speed_100_in, // negotiated speed
    input wire logic an_full_duplex_in, // negotiated duplex
    input wire logic [15:0] lp_ability_in, // partner ability word
    output logic phy_soft_rst, // soft reset in progress
    output logic an_restart, // restart negotiation pulse
    output logic an_enable, // negotiation enabled
    output logic loopback_en, // loopback mode
    output logic power_down, // general power-down
    output logic speed_100, // effective speed
    output logic full_duplex, // effective duplex
    output logic col_test_en // collision test enable
);
    import phybm_pkg::*;

    logic [15:0] ctrl_r;
    logic [15:0] an_adv_r;
    logic [15:0] vend_mem [VEND_SLOTS];
    logic strap_meta_r;
    logic strap_sync_r;
    logic strap_load_r;
    logic an_cmpl_r;
    logic an_restart_r;
    logic pd_prev_r;
    logic speed_100_r;
    logic full_duplex_r;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic srst_busy;
    logic srst_done;
    logic state_rst;
    logic stat_rd;
    logic rfault_held;
    logic link_held;
    logic jabber_held;
    logic ctrl_wr;
    logic vend_hit;
    logic [2:0] vend_slot;
    logic [15:0] stat_word;
    logic [15:0] rd_word;
    logic pd_fall;

    // the soft reset returns register and status state to defaults when its interval ends; the read data register keeps its value
    assign state_rst = sys_rst | srst_done;
    assign ctrl_wr = acc_wr && (acc_index == IDX_BASIC_CTRL) && !srst_busy;
    assign stat_rd = acc_rd && (acc_index == IDX_BASIC_STAT);
    assign pd_fall = pd_prev_r && !ctrl_r[CTRL_PWR_DOWN];

    // strap pin is asynchronous; not reset so it settles while reset is held
    always_ff @(posedge ref_clk) begin
        strap_meta_r <= speed_sel_pin;
        strap_sync_r <= strap_meta_r;
    end

    // strap is taken one cycle after release, never inside the reset branch
    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            strap_load_r <= 1'b1;
        end else begin
            strap_load_r <= 1'b0;
        end
    end

    phybm_timer #(
        .W(TMR_W),
        .COUNT(TMR_W'(SOFT_RST_CYC))
    ) u_srst_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(ctrl_wr && acc_wdata[CTRL_SOFT_RST]),
        .busy(srst_busy),
        .done(srst_done)
    );

    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            ctrl_r <= CTRL_RST_VAL;
        end else begin
            // a write in the first cycle after reset wins over the strap, so it is never lost
            if (ctrl_wr) begin
                // reserved bits stay zero
                ctrl_r <= acc_wdata & CTRL_WR_MASK;
            end else if (strap_load_r) begin
                ctrl_r[CTRL_SPEED] <= strap_sync_r;
                ctrl_r[CTRL_AN_EN] <= strap_sync_r;
            end else if (ctrl_r[CTRL_AN_RESTART]) begin
                ctrl_r[CTRL_AN_RESTART] <= 1'b0;
            end
        end
    end

    // restart pulse follows a restart request or leaving power-down, only while negotiation is enabled
    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            pd_prev_r <= 1'b0;
            an_restart_r <= 1'b0;
        end else begin
            pd_prev_r <= ctrl_r[CTRL_PWR_DOWN];
            an_restart_r <= ctrl_r[CTRL_AN_EN] && (ctrl_r[CTRL_AN_RESTART] || pd_fall);
        end
    end

    // a completion in the same cycle as the restart pulse is kept
    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            an_cmpl_r <= 1'b0;
        end else if (an_done_in && ctrl_r[CTRL_AN_EN] && !ctrl_r[CTRL_PWR_DOWN]) begin
            an_cmpl_r <= 1'b1;
        end else if (an_restart_r || ctrl_r[CTRL_PWR_DOWN] || !ctrl_r[CTRL_AN_EN]) begin
            an_cmpl_r <= 1'b0;
        end
    end

    // manual speed and duplex only matter with negotiation off
    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            speed_100_r <= 1'b0;
            full_duplex_r <= 1'b0;
        end else if (ctrl_r[CTRL_AN_EN]) begin
            speed_100_r <= an_speed_100_in;
            full_duplex_r <= an_full_duplex_in;
        end else begin
            speed_100_r <= ctrl_r[CTRL_SPEED];
            full_duplex_r <= ctrl_r[CTRL_DUPLEX];
        end
    end

    phybm_status_latch #(
        .LATCH_HIGH(1'b1)
    ) u_rfault (
        .ref_clk(ref_clk),
        .sys_rst(state_rst),
        .live(remote_fault_in),
        .rd_clr(stat_rd),
        .held(rfault_held)
    );

    phybm_status_latch #(
        .LATCH_HIGH(1'b0)
    ) u_link (
        .ref_clk(ref_clk),
        .sys_rst(state_rst),
        .live(link_up_in),
        .rd_clr(stat_rd),
        .held(link_held)
    );

    phybm_status_latch #(
        .LATCH_HIGH(1'b1)
    ) u_jabber (
        .ref_clk(ref_clk),
        .sys_rst(state_rst),
        .live(jabber_in),
        .rd_clr(stat_rd),
        .held(jabber_held)
    );

    always_comb begin
        stat_word = STAT_FIXED;
        stat_word[STAT_AN_DONE] = an_cmpl_r;
        stat_word[STAT_RFAULT] = rfault_held;
        stat_word[STAT_LINK] = link_held;
        stat_word[STAT_JABBER] = jabber_held;
    end

    always_comb begin
        vend_hit = 1'b1;
        vend_slot = SLOT_MODE_CTRL;
        unique case (acc_index)
            IDX_MODE_CTRL: vend_slot = SLOT_MODE_CTRL;
            IDX_SPEC_MODES: vend_slot = SLOT_SPEC_MODES;
            IDX_SPEC_IND: vend_slot = SLOT_SPEC_IND;
            IDX_IRQ_SRC: vend_slot = SLOT_IRQ_SRC;
            IDX_IRQ_MASK: vend_slot = SLOT_IRQ_MASK;
            IDX_SPEC_CTRL: vend_slot = SLOT_SPEC_CTRL;
            default: vend_hit = 1'b0;
        endcase
    end

    // vendor layouts are not modelled: plain storage only
    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            for (int i = 0; i < VEND_SLOTS; i++) begin
                vend_mem[i] <= VEND_RST_VAL;
            end
        end else if (acc_wr && vend_hit && !srst_busy) begin
            vend_mem[vend_slot] <= acc_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (state_rst) begin
            an_adv_r <= AN_ADV_RST_VAL;
        end else if (acc_wr && (acc_index == IDX_AN_ADV) && !srst_busy) begin
            an_adv_r <= acc_wdata;
        end
    end

    always_comb begin
        rd_word = READ_ZERO;
        unique case (acc_index)
            IDX_BASIC_CTRL: rd_word = ctrl_r;
            IDX_BASIC_STAT: rd_word = stat_word;
            IDX_IDENT_HIGH: rd_word = IDENT_HIGH;
            IDX_IDENT_LOW: rd_word = IDENT_LOW;
            IDX_AN_ADV: rd_word = an_adv_r;
            IDX_AN_PARTNER: rd_word = lp_ability_in;
            IDX_AN_EXPAN: rd_word = READ_ZERO;
            default: rd_word = vend_hit ? vend_mem[vend_slot] : READ_ZERO;
        endcase
    end

    // the word returned is the one latched before the read clears it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= READ_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= acc_rd;
            if (acc_rd) begin
                rdata_r <= rd_word;
            end
        end
    end

    assign acc_rdata = rdata_r;
    assign acc_rvalid = rvalid_r;
    assign phy_soft_rst = srst_busy;
    assign an_restart = an_restart_r;
    assign an_enable = ctrl_r[CTRL_AN_EN];
    assign loopback_en = ctrl_r[CTRL_LOOPBACK];
    assign power_down = ctrl_r[CTRL_PWR_DOWN];
    assign speed_100 = speed_100_r;
    assign full_duplex = full_duplex_r;
    assign col_test_en = ctrl_r[CTRL_COL_TEST];

endmodule

// ===== design/phybm_status_latch.sv
`timescale 1ns/1ps
module phybm_status_latch #(
    parameter bit LATCH_HIGH = 1'b1
) (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // synchronous reset, also soft reset
    input wire logic live, // live condition
    input wire logic rd_clr, // status register read
    output logic held // latched value
);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            held <= 1'b0;
        end else if (rd_clr) begin
            // after a read the bit tracks the live condition again
            held <= live;
        end else if (LATCH_HIGH) begin
            held <= held | live;
        end else begin
            held <= held & live;
        end
    end
endmodule

// ===== design/phybm_timer.sv
`timescale 1ns/1ps
module phybm_timer #(
    parameter int W = 12,
    parameter logic [W-1:0] COUNT = '1
) (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // synchronous reset
    input wire logic start, // start pulse, ignored while busy
    output logic busy, // counting
    output logic done // one-cycle pulse at the end
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (busy) begin
                // done lands on the last busy cycle so state clears before writes reopen;
                // a count of 1 gives no done pulse
                if (cnt_r == W'(2)) begin
                    done <= 1'b1;
                end
                if (cnt_r == W'(1)) begin
                    busy <= 1'b0;
                end
                cnt_r <= cnt_r - W'(1);
            end else if (start) begin
                busy <= 1'b1;
                cnt_r <= COUNT;
            end
        end
    end
endmodule

// ===== testbench/phybm_host.sv
`timescale 1ns/1ps
module phybm_host (
    input wire logic ref_clk, // clock
    output logic [4:0] acc_index = 5'h00, // register index
    output logic acc_wr = 1'b0, // write strobe
    output logic acc_rd = 1'b0, // read strobe
    output logic [15:0] acc_wdata = 16'h0000, // write data
    input wire logic [15:0] acc_rdata, // read data
    input wire logic acc_rvalid // read valid
);
    // only index plus data reach the device, nothing is memory mapped
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        @(posedge ref_clk);
        acc_index <= idx;
        acc_wdata <= d;
        acc_wr <= 1'b1;
        @(posedge ref_clk);
        acc_wr <= 1'b0;
        acc_wdata <= ~d; // released data must not look valid
    endtask
    task automatic rd(input logic [4:0] idx, output logic [15:0] d);
        @(posedge ref_clk);
        acc_index <= idx;
        acc_rd <= 1'b1;
        @(posedge ref_clk);
        acc_rd <= 1'b0;
        @(posedge ref_clk);
        d = acc_rvalid ? acc_rdata : 16'hxxxx;
    endtask
endmodule

// ===== testbench/phybm_regs_chk.sv
`timescale 1ns/1ps
module phybm_regs_chk #(
    parameter logic [15:0] IDENT_HIGH = 16'h1234 // arbitrary value
) (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [4:0] acc_index, // index
    input wire logic acc_wr, // write strobe
    input wire logic acc_rd, // read strobe
    input wire logic [15:0] acc_wdata, // write data
    input wire logic [15:0] acc_rdata, // read data
    input wire logic acc_rvalid, // read valid
    input wire logic link_up_in, // live link
    input wire logic jabber_in, // live jabber
    input wire logic an_speed_100_in, // negotiated speed
    input wire logic an_full_duplex_in, // negotiated duplex
    input wire logic phy_soft_rst, // soft reset
    input wire logic an_restart, // restart pulse
    input wire logic an_enable, // negotiation on
    input wire logic loopback_en, // loopback
    input wire logic power_down, // power-down
    input wire logic speed_100, // speed
    input wire logic full_duplex, // duplex
    input wire logic col_test_en // collision test
);
    import phybm_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic cw;
    logic st_rd;
    // writes during soft reset are dropped, so they are left out
    assign cw = acc_wr && acc_index == IDX_BASIC_CTRL && !phy_soft_rst;
    assign st_rd = acc_rd && acc_index == IDX_BASIC_STAT && !phy_soft_rst;
    property p_rd_ans; acc_rd |=> acc_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read without answer");
    property p_rv_src; acc_rvalid |-> $past(acc_rd); endproperty
    a_rv_src: assert property (p_rv_src) else $error("answer without read");
    property p_srst_go; cw && acc_wdata[15] |=> phy_soft_rst; endproperty
    a_srst_go: assert property (p_srst_go) else $error("soft reset not started");
    property p_srst_len; $fell(phy_soft_rst) |-> $past(phy_soft_rst, 200) && !$past(phy_soft_rst, 201); endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
    property p_mode; cw && !acc_wdata[15] |=> loopback_en == $past(acc_wdata[14]) && power_down == $past(acc_wdata[11])
        && col_test_en == $past(acc_wdata[7]) && an_enable == $past(acc_wdata[12]); endproperty
    a_mode: assert property (p_mode) else $error("mode outputs wrong");
    property p_rst_pls; cw && acc_wdata[9] && acc_wdata[12] && !acc_wdata[15] |-> ##2 an_restart ##1 !an_restart; endproperty
    a_rst_pls: assert property (p_rst_pls) else $error("restart pulse wrong");
    property p_an_sel; an_enable |=> speed_100 == $past(an_speed_100_in) && full_duplex == $past(an_full_duplex_in); endproperty
    a_an_sel: assert property (p_an_sel) else $error("negotiated mode not used");
    property p_man_sel; cw && !acc_wdata[12] && !acc_wdata[15] |->
        ##2 (speed_100 == $past(acc_wdata[13], 2) && full_duplex == $past(acc_wdata[8], 2)); endproperty
    a_man_sel: assert property (p_man_sel) else $error("manual mode not used");
    property p_fixed; acc_rd && acc_index == IDX_BASIC_STAT |=> acc_rdata[15:6] == 10'h1e0 && acc_rdata[3] && acc_rdata[0];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
    property p_ident; acc_rd && acc_index == IDX_IDENT_HIGH |=> acc_rdata == IDENT_HIGH; endproperty
    a_ident: assert property (p_ident) else $error("identifier wrong");
    property p_jab; st_rd && $past(jabber_in) && !$past(sys_rst) && !$past(phy_soft_rst) |=> acc_rdata[1]; endproperty
    a_jab: assert property (p_jab) else $error("jabber not held");
    property p_link; st_rd && !$past(link_up_in) && !$past(sys_rst) && !$past(phy_soft_rst) |=> !acc_rdata[2]; endproperty
    a_link: assert property (p_link) else $error("link loss not held");
endmodule
bind phybm_regs phybm_regs_chk #(.IDENT_HIGH(IDENT_HIGH)) u_chk (.ref_clk, .sys_rst, .acc_index, .acc_wr, .acc_rd,
    .acc_wdata, .acc_rdata, .acc_rvalid, .link_up_in, .jabber_in, .an_speed_100_in, .an_full_duplex_in, .phy_soft_rst,
    .an_restart, .an_enable, .loopback_en, .power_down, .speed_100, .full_duplex, .col_test_en);

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import phybm_pkg::*;
    localparam logic [15:0] IDH = 16'h5a3c; // arbitrary value
    localparam logic [15:0] IDL = 16'h0f1e; // arbitrary value
    logic ref_clk, sys_rst, speed_sel_pin, link_up_in, remote_fault_in, jabber_in, an_done_in;
    logic an_speed_100_in, an_full_duplex_in, acc_wr, acc_rd, acc_rvalid;
    logic phy_soft_rst, an_restart, an_enable, loopback_en, power_down, speed_100, full_duplex, col_test_en;
    logic [4:0] acc_index;
    logic [15:0] acc_wdata, acc_rdata, v;
    logic [15:0] lp_ability_in = 16'h45e1;
    logic [4:0] vid [6] = '{IDX_MODE_CTRL, IDX_SPEC_MODES, IDX_SPEC_IND, IDX_IRQ_SRC, IDX_IRQ_MASK, IDX_SPEC_CTRL};
    int errors = 0;
    int n_compared = 0;
    phybm_regs #(.IDENT_HIGH(IDH), .IDENT_LOW(IDL)) u_dut (.ref_clk, .sys_rst, .acc_index, .acc_wr, .acc_rd,
        .acc_wdata, .acc_rdata, .acc_rvalid, .speed_sel_pin, .link_up_in, .remote_fault_in, .jabber_in, .an_done_in,
        .an_speed_100_in, .an_full_duplex_in, .lp_ability_in, .phy_soft_rst, .an_restart, .an_enable, .loopback_en,
        .power_down, .speed_100, .full_duplex, .col_test_en);
    phybm_host u_host (.ref_clk, .acc_index, .acc_wr, .acc_rd, .acc_wdata, .acc_rdata, .acc_rvalid);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [4:0] idx, input logic [15:0] exp);
        u_host.rd(idx, v);
        chk(v, exp);
    endtask
    task automatic live(input logic l, input logic f, input logic j, input logic d);
        @(posedge ref_clk);
        link_up_in <= l;
        remote_fault_in <= f;
        jabber_in <= j;
        an_done_in <= d;
    endtask
    task automatic print_verdict;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        $display("unexpected at %0t: timeout", $time);
        print_verdict();
    end
    initial begin
        {sys_rst, speed_sel_pin, an_speed_100_in} = 3'h7;
        {link_up_in, remote_fault_in, jabber_in, an_done_in, an_full_duplex_in} = 5'h00;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rc(IDX_BASIC_CTRL, 16'h3000);
        rc(IDX_BASIC_STAT, 16'h7809);
        u_host.wr(IDX_IDENT_HIGH, 16'hffff);
        rc(IDX_IDENT_HIGH, IDH);
        rc(IDX_IDENT_LOW, IDL);
        rc(IDX_AN_ADV, 16'h0001);
        u_host.wr(IDX_AN_ADV, 16'h01e1);
        rc(IDX_AN_ADV, 16'h01e1);
        rc(IDX_AN_PARTNER, 16'h45e1);
        rc(IDX_AN_EXPAN, 16'h0000);
        u_host.wr(5'h07, 16'h1111);
        rc(5'h07, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            u_host.wr(vid[i], 16'ha5c0 + 16'(i));
        end
        for (int i = 0; i < 6; i++) begin
            rc(vid[i], 16'ha5c0 + 16'(i));
        end
        live(1'b1, 1'b0, 1'b0, 1'b0);
        rc(IDX_BASIC_STAT, 16'h7809);
        rc(IDX_BASIC_STAT, 16'h780d);
        live(1'b0, 1'b1, 1'b1, 1'b0);
        live(1'b1, 1'b0, 1'b0, 1'b0);
        rc(IDX_BASIC_STAT, 16'h781b);
        rc(IDX_BASIC_STAT, 16'h780d);
        live(1'b0, 1'b1, 1'b1, 1'b0);
        rc(IDX_BASIC_STAT, 16'h781b);
        live(1'b1, 1'b0, 1'b0, 1'b0);
        u_host.rd(IDX_BASIC_STAT, v);
        rc(IDX_BASIC_STAT, 16'h780d);
        live(1'b1, 1'b0, 1'b0, 1'b1);
        live(1'b1, 1'b0, 1'b0, 1'b0);
        rc(IDX_BASIC_STAT, 16'h782d);
        u_host.wr(IDX_BASIC_CTRL, 16'h1200);
        // completion clears only when the restart pulse arrives, two edges after the write
        @(posedge ref_clk);
        rc(IDX_BASIC_STAT, 16'h780d);
        rc(IDX_BASIC_CTRL, 16'h1000);
        chk({14'h0, speed_100, full_duplex}, 16'h0002);
        u_host.wr(IDX_BASIC_CTRL, 16'h1800);
        live(1'b1, 1'b0, 1'b0, 1'b1);
        live(1'b1, 1'b0, 1'b0, 1'b0);
        rc(IDX_BASIC_STAT, 16'h780d);
        u_host.wr(IDX_BASIC_CTRL, 16'h1000);
        live(1'b1, 1'b0, 1'b0, 1'b1);
        live(1'b1, 1'b0, 1'b0, 1'b0);
        rc(IDX_BASIC_STAT, 16'h782d);
        u_host.wr(IDX_BASIC_CTRL, 16'h6180);
        rc(IDX_BASIC_CTRL, 16'h6180);
        chk({12'h0, loopback_en, speed_100, full_duplex, col_test_en}, 16'h000f);
        u_host.wr(IDX_BASIC_CTRL, 16'h0c7f);
        rc(IDX_BASIC_CTRL, 16'h0800);
        chk({15'h0, power_down}, 16'h0001);
        u_host.wr(IDX_BASIC_CTRL, 16'h8000);
        rc(IDX_BASIC_CTRL, 16'h8000);
        chk({15'h0, phy_soft_rst}, 16'h0001);
        u_host.wr(IDX_BASIC_CTRL, 16'h4000);
        rc(IDX_BASIC_CTRL, 16'h8000);
        for (int i = 0; i < 300 && phy_soft_rst; i++) begin
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
        rc(IDX_BASIC_CTRL, 16'h3000);
        rc(vid[0], 16'h0000);
        rc(IDX_AN_ADV, 16'h0001);
        print_verdict();
    end
endmodule
